// ==== pkg/ilcgd_pkg.sv ====
// ilcgd_pkg: constants and types for the inband loop code generator and detector
// assumes one 10 MHz system clock and byte-wide registers at their printed offsets
package ilcgd_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] ILCGD_OFS_SEND_CTRL = 12'h074;
	localparam logic [11:0] ILCGD_OFS_SEND_PATTERN = 12'h075;
	localparam logic [11:0] ILCGD_OFS_DETECT_CONFIG = 12'h076;
	localparam logic [11:0] ILCGD_OFS_DETECT_STATE = 12'h077;
	localparam logic [11:0] ILCGD_OFS_UP_TARGET = 12'h078;
	localparam logic [11:0] ILCGD_OFS_DOWN_TARGET = 12'h079;
	localparam logic [11:0] ILCGD_OFS_IRQ_ENABLE = 12'h07A;
	localparam logic [11:0] ILCGD_OFS_IRQ_FLAGS = 12'h07B;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] ILCGD_RST_SEND_CTRL = 8'h00;
	localparam logic [7:0] ILCGD_RST_SEND_PATTERN = 8'h00;
	localparam logic [7:0] ILCGD_RST_DETECT_CONFIG = 8'h04;
	localparam logic [7:0] ILCGD_RST_UP_TARGET = 8'h08;
	localparam logic [7:0] ILCGD_RST_DOWN_TARGET = 8'h24;
	localparam logic [7:0] ILCGD_RST_IRQ_ENABLE = 8'h00;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int ILCGD_BIT_SEND_EN = 3;
	localparam int ILCGD_BIT_UNFRAMED = 2;
	localparam int ILCGD_POS_SEND_LEN = 0;
	localparam int ILCGD_BIT_FBIT_SKIP = 4;
	localparam int ILCGD_POS_DOWN_SEL = 2;
	localparam int ILCGD_POS_UP_SEL = 0;
	// detector index doubles as the bit position in state, enable and flag registers
	localparam int ILCGD_DET_DOWN = 0;
	localparam int ILCGD_DET_UP = 1;

	// ----------------------------------------------------------------
	// timing and thresholds
	// ----------------------------------------------------------------
	localparam int unsigned ILCGD_CLK_NS = 100;
	localparam int unsigned ILCGD_PERIOD_NS = 39800000;
	localparam int unsigned ILCGD_PERIOD_CYC = ILCGD_PERIOD_NS / ILCGD_CLK_NS;
	localparam logic [9:0] ILCGD_ERR_LIMIT = 10'h258;
	localparam logic [6:0] ILCGD_GOOD_LIMIT = 7'h7E;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic en;
		logic fbit;
		logic data;
	} ilcgd_bit_t;

endpackage : ilcgd_pkg

// ==== src/ilcgd_top.sv ====
// ilcgd_top: inband loopback code sender and activate/deactivate code detector
// assumes bit strobes on the link structs are synchronous to clk_sys, one cycle each
`timescale 1ns/10ps

module ilcgd_top
	import ilcgd_pkg::*;
#(
	parameter int unsigned PERIOD_CYCLES = ILCGD_PERIOD_CYC
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [11:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire ilcgd_bit_t tx_in,
	output ilcgd_bit_t tx_out,
	input wire ilcgd_bit_t rx_in,
	output logic loop_up_present,
	output logic loop_down_present,
	output logic irq_n
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// last code bit index for a two-bit length select: 00 -> 4 ... 11 -> 7
	function automatic logic [2:0] ilcgd_last_idx(input logic [1:0] sel);
		case (sel)
			2'h0: ilcgd_last_idx = 3'h4;
			2'h1: ilcgd_last_idx = 3'h5;
			2'h2: ilcgd_last_idx = 3'h6;
			2'h3: ilcgd_last_idx = 3'h7;
			default: ilcgd_last_idx = 3'h4;
		endcase
	endfunction : ilcgd_last_idx

	// exact match of the full register offset
	function automatic logic ilcgd_hit(input logic [11:0] addr, input logic [11:0] ofs);
		ilcgd_hit = (addr == ofs);
	endfunction : ilcgd_hit

	// code bit at a phase, bit 7 of the pattern first
	function automatic logic ilcgd_code_bit(input logic [7:0] pat, input logic [2:0] phase);
		ilcgd_code_bit = pat[3'h7 - phase];
	endfunction : ilcgd_code_bit

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [3:0] send_ctrl_q;
	logic [7:0] send_code_pattern_q;
	logic [4:0] detect_config_q;
	logic [7:0] loop_up_pattern_q;
	logic [7:0] loop_down_pattern_q;
	logic [1:0] irq_enable_q;
	logic [1:0] change_flag_q;
	logic [1:0] change_flag_d;
	logic [1:0] present_q;
	wire [1:0] present_d;

	// a write to the state offset is dropped: there is nothing behind it
	wire wr_send_ctrl = reg_wr && ilcgd_hit(reg_addr, ILCGD_OFS_SEND_CTRL);
	wire wr_send_pat = reg_wr && ilcgd_hit(reg_addr, ILCGD_OFS_SEND_PATTERN);
	wire wr_config = reg_wr && ilcgd_hit(reg_addr, ILCGD_OFS_DETECT_CONFIG);
	wire wr_up_tgt = reg_wr && ilcgd_hit(reg_addr, ILCGD_OFS_UP_TARGET);
	wire wr_down_tgt = reg_wr && ilcgd_hit(reg_addr, ILCGD_OFS_DOWN_TARGET);
	wire wr_irq_en = reg_wr && ilcgd_hit(reg_addr, ILCGD_OFS_IRQ_ENABLE);
	wire wr_flags = reg_wr && ilcgd_hit(reg_addr, ILCGD_OFS_IRQ_FLAGS);
	wire rd_flags = reg_rd && ilcgd_hit(reg_addr, ILCGD_OFS_IRQ_FLAGS);

	wire code_send_enable = send_ctrl_q[ILCGD_BIT_SEND_EN];
	wire unframed_send_select = send_ctrl_q[ILCGD_BIT_UNFRAMED];
	wire [1:0] send_code_length = send_ctrl_q[ILCGD_POS_SEND_LEN +: 2];
	wire framing_bit_skip = detect_config_q[ILCGD_BIT_FBIT_SKIP];
	wire [1:0] loop_down_len_sel = detect_config_q[ILCGD_POS_DOWN_SEL +: 2];
	wire [1:0] loop_up_len_sel = detect_config_q[ILCGD_POS_UP_SEL +: 2];

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			send_ctrl_q <= ILCGD_RST_SEND_CTRL[3:0];
		end else if (wr_send_ctrl) begin
			send_ctrl_q <= reg_wdata[3:0];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			send_code_pattern_q <= ILCGD_RST_SEND_PATTERN;
		end else if (wr_send_pat) begin
			send_code_pattern_q <= reg_wdata;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			detect_config_q <= ILCGD_RST_DETECT_CONFIG[4:0];
		end else if (wr_config) begin
			detect_config_q <= reg_wdata[4:0];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			loop_up_pattern_q <= ILCGD_RST_UP_TARGET;
		end else if (wr_up_tgt) begin
			loop_up_pattern_q <= reg_wdata;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			loop_down_pattern_q <= ILCGD_RST_DOWN_TARGET;
		end else if (wr_down_tgt) begin
			loop_down_pattern_q <= reg_wdata;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq_enable_q <= ILCGD_RST_IRQ_ENABLE[1:0];
		end else if (wr_irq_en) begin
			irq_enable_q <= reg_wdata[1:0];
		end
	end

	// ----------------------------------------------------------------
	// read port
	// ----------------------------------------------------------------
	// reserved and unmapped bits read as zero
	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = 8'h00;
		case (reg_addr)
			ILCGD_OFS_SEND_CTRL: rd_mux = {4'h0, send_ctrl_q};
			ILCGD_OFS_SEND_PATTERN: rd_mux = send_code_pattern_q;
			ILCGD_OFS_DETECT_CONFIG: rd_mux = {3'h0, detect_config_q};
			ILCGD_OFS_DETECT_STATE: rd_mux = {6'h00, present_q};
			ILCGD_OFS_UP_TARGET: rd_mux = loop_up_pattern_q;
			ILCGD_OFS_DOWN_TARGET: rd_mux = loop_down_pattern_q;
			ILCGD_OFS_IRQ_ENABLE: rd_mux = {6'h00, irq_enable_q};
			ILCGD_OFS_IRQ_FLAGS: rd_mux = {6'h00, change_flag_q};
			default: rd_mux = 8'h00;
		endcase
	end

	// zero outside the answer cycle, so a stale value never looks valid
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rd_mux;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// transmit code insertion
	// ----------------------------------------------------------------
	logic [2:0] tx_phase_q;
	wire [2:0] tx_last = ilcgd_last_idx(send_code_length);
	// framed mode leaves the F-bit alone and does not advance the code phase
	wire tx_take = code_send_enable && (!tx_in.fbit || unframed_send_select);
	wire tx_code_bit = ilcgd_code_bit(send_code_pattern_q, tx_phase_q);
	wire [2:0] tx_phase_nx = (tx_phase_q >= tx_last) ? 3'h0 : tx_phase_q + 3'h1;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_out <= '0;
		end else begin
			tx_out.en <= tx_in.en;
			tx_out.fbit <= tx_in.fbit;
			tx_out.data <= tx_take ? tx_code_bit : tx_in.data;
		end
	end

	// ----------------------------------------------------------------
	// transmit code phase
	// ----------------------------------------------------------------
	// cleared while idle so every enable starts at pattern bit 7
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_phase_q <= 3'h0;
		end else if (!code_send_enable) begin
			tx_phase_q <= 3'h0;
		end else if (tx_in.en && tx_take) begin
			tx_phase_q <= tx_phase_nx;
		end
	end

	// ----------------------------------------------------------------
	// fixed detection period
	// ----------------------------------------------------------------
	logic [31:0] period_cnt_q;
	wire period_end = (period_cnt_q >= 32'(PERIOD_CYCLES - 1));

	// free running: periods are fixed, not aligned to the received code
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			period_cnt_q <= 32'h0;
		end else if (period_end) begin
			period_cnt_q <= 32'h0;
		end else begin
			period_cnt_q <= 32'(period_cnt_q + 32'h1);
		end
	end

	// ----------------------------------------------------------------
	// detectors: index 0 loop-down, index 1 loop-up
	// ----------------------------------------------------------------
	// an F-bit that is skipped neither advances the phase nor counts
	wire rx_seen = rx_in.en && !(rx_in.fbit && framing_bit_skip);
	// a compared F-bit advances the phase on a match but is never counted as an error
	wire rx_counts = rx_seen && !rx_in.fbit;
	wire [7:0] tgt_pat [2];
	wire [1:0] tgt_sel [2];
	assign tgt_pat[ILCGD_DET_DOWN] = loop_down_pattern_q;
	assign tgt_pat[ILCGD_DET_UP] = loop_up_pattern_q;
	assign tgt_sel[ILCGD_DET_DOWN] = loop_down_len_sel;
	assign tgt_sel[ILCGD_DET_UP] = loop_up_len_sel;

	genvar k;
	generate
		for (k = 0; k < 2; k++) begin : g_det
			logic [2:0] phase_q;
			logic [9:0] err_q;
			logic [6:0] good_q;
			wire [2:0] last = ilcgd_last_idx(tgt_sel[k]);
			// bit 7 is compared against the first code bit; lower unused bits never reached
			wire expect_bit = ilcgd_code_bit(tgt_pat[k], phase_q);
			wire miss = rx_seen && (rx_in.data != expect_bit);
			wire bit_err = miss && rx_counts;
			// phase holds on a miss, so alignment hunts at a cost of a few errors
			wire [2:0] phase_nx = (phase_q >= last) ? 3'h0 : phase_q + 3'h1;
			wire [9:0] err_now = (bit_err && err_q != 10'h3FF) ? err_q + 10'h001 : err_q;
			wire per_bad = err_now > ILCGD_ERR_LIMIT;
			wire per_good = err_now < ILCGD_ERR_LIMIT;
			wire [6:0] good_nx = (good_q == 7'h7F) ? good_q : good_q + 7'h01;
			assign present_d[k] = !period_end ? present_q[k] :
				per_bad ? 1'b0 :
				(per_good && good_q >= ILCGD_GOOD_LIMIT) ? 1'b1 : present_q[k];

			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					phase_q <= 3'h0;
				end else if (rx_seen && !miss) begin
					phase_q <= phase_nx;
				end else if (phase_q > last) begin
					phase_q <= 3'h0;
				end
			end

			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					err_q <= 10'h000;
					good_q <= 7'h00;
				end else if (period_end) begin
					err_q <= 10'h000;
					good_q <= per_good ? good_nx : 7'h00;
				end else begin
					err_q <= err_now;
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// change flags and interrupt
	// ----------------------------------------------------------------
	wire [1:0] flag_set = present_d ^ present_q;
	// a read of the flag register clears too; a fresh change always wins
	wire [1:0] flag_clr = (wr_flags ? reg_wdata[1:0] : 2'h0) | {2{rd_flags}};
	assign change_flag_d = flag_set | (change_flag_q & ~flag_clr);
	wire irq_any = |(change_flag_d & irq_enable_q);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			present_q <= 2'h0;
		end else begin
			present_q <= present_d;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			change_flag_q <= 2'h0;
		end else begin
			change_flag_q <= change_flag_d;
		end
	end

	// from the next flag value, so the pin falls with the flag, not a cycle later
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq_n <= 1'b1;
		end else begin
			irq_n <= !irq_any;
		end
	end

	// ----------------------------------------------------------------
	// status pins
	// ----------------------------------------------------------------
	// mirror the state register in the same cycle
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			loop_up_present <= 1'b0;
			loop_down_present <= 1'b0;
		end else begin
			loop_up_present <= present_d[ILCGD_DET_UP];
			loop_down_present <= present_d[ILCGD_DET_DOWN];
		end
	end

endmodule : ilcgd_top

// ==== dv/ilcgd_props.sv ====
// ilcgd_props: port-level checker for ilcgd_top
// assumes it is bound into ilcgd_top and shadows host register writes
`timescale 1ns/10ps
module ilcgd_props
	import ilcgd_pkg::*;
#(
	parameter int unsigned PERIOD_CYCLES = 40
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [11:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire ilcgd_bit_t tx_in,
	input wire ilcgd_bit_t tx_out,
	input wire ilcgd_bit_t rx_in,
	input wire logic loop_up_present,
	input wire logic loop_down_present,
	input wire logic irq_n
);
	// ----
	// shadow state
	// ----
	logic [1:0] ctl_q;
	logic [1:0] ie_q;
	int unsigned cyc_q;
	wire logic wr_ctl = reg_wr && reg_addr == ILCGD_OFS_SEND_CTRL;
	wire logic wr_ie = reg_wr && reg_addr == ILCGD_OFS_IRQ_ENABLE;
	wire logic clr_a = reg_rd || (reg_wr && reg_wdata[1:0] == 2'h3);
	wire logic fl_clr = reg_addr == ILCGD_OFS_IRQ_FLAGS && clr_a;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctl_q <= 2'h0;
			ie_q <= 2'h0;
			cyc_q <= 0;
		end else begin
			ctl_q <= wr_ctl ? reg_wdata[3:2] : ctl_q;
			ie_q <= wr_ie ? reg_wdata[1:0] : ie_q;
			cyc_q <= cyc_q + 1;
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// counts from reset, so a rise can only trail the full good-period run
	property p_up; $rose(loop_up_present) |-> cyc_q >= 126 * PERIOD_CYCLES; endproperty
	a_up: assert property (p_up) else $error("up early");
	property p_dn; $rose(loop_down_present) |-> cyc_q >= 126 * PERIOD_CYCLES; endproperty
	a_dn: assert property (p_dn) else $error("down early");
	property p_pass; $past(!ctl_q[1]) |-> tx_out == $past(tx_in); endproperty
	a_pass: assert property (p_pass) else $error("tx pass");
	property p_frm; $past(ctl_q == 2'h2 && tx_in.fbit) |-> tx_out.data == $past(tx_in.data); endproperty
	a_frm: assert property (p_frm) else $error("fbit lost");
	property p_uirq; $changed(loop_up_present) && ie_q[1] |-> !irq_n; endproperty
	a_uirq: assert property (p_uirq) else $error("up irq");
	property p_dirq; $changed(loop_down_present) && ie_q[0] |-> !irq_n; endproperty
	a_dirq: assert property (p_dirq) else $error("down irq");
	property p_mask; !irq_n |-> (|ie_q) || (|$past(ie_q)); endproperty
	a_mask: assert property (p_mask) else $error("irq masked");
	property p_clr; $past(fl_clr) && $stable(loop_up_present) && $stable(loop_down_present) |-> irq_n; endproperty
	a_clr: assert property (p_clr) else $error("irq clear");
	c_up: cover property ($rose(loop_up_present));
	c_lo: cover property ($fell(loop_up_present));
	c_irq: cover property ($fell(irq_n));
endmodule : ilcgd_props
bind ilcgd_top ilcgd_props #(.PERIOD_CYCLES(PERIOD_CYCLES)) ilcgd_props_i (.clk_sys(clk_sys),
	.rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .tx_in(tx_in), .tx_out(tx_out), .rx_in(rx_in), .irq_n(irq_n),
	.loop_up_present(loop_up_present), .loop_down_present(loop_down_present));

// ==== dv/ilcgd_line_model.sv ====
// ilcgd_line_model: far-end equipment sending a repeating loop code
// assumes one received bit per clk_sys cycle
`timescale 1ns/10ps
module ilcgd_line_model
	import ilcgd_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [7:0] code,
	input wire logic [3:0] code_len,
	input wire logic corrupt,
	output ilcgd_bit_t rx_out
);
	// ----
	// code source
	// ----
	logic [3:0] ph_q;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ph_q <= 4'h0;
			rx_out <= '0;
		end else begin
			ph_q <= (ph_q == code_len - 4'h1) ? 4'h0 : ph_q + 4'h1;
			// all ones breaks a zero-rich code on nearly every bit
			rx_out <= '{en: 1'h1, fbit: 1'h0, data: corrupt | code[3'h7 - ph_q[2:0]]};
		end
	end
endmodule : ilcgd_line_model

// ==== dv/ilcgd_top_tb.sv ====
// ilcgd_top_tb: register, transmit and detector checks for ilcgd_top
// assumes a shortened detector period of PER cycles
`timescale 1ns/10ps
module ilcgd_top_tb
	import ilcgd_pkg::*;
();
	localparam int unsigned PER = 620;
	localparam logic [7:0] PAT = 8'hB5;
	logic clk_sys = 1'h0;
	logic rst_n = 1'h0;
	logic [11:0] reg_addr = 12'h000;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'h0;
	logic reg_rd = 1'h0;
	logic corrupt = 1'h0;
	logic [7:0] reg_rdata;
	ilcgd_bit_t tx_in = '0;
	ilcgd_bit_t tx_out;
	ilcgd_bit_t rx_in;
	logic up, dn, irq_n;
	int bad_count = 0;
	int checks = 0;
	int unsigned cyc = 0;
	logic [11:0] ofs [9] = '{12'h074, 12'h075, 12'h076, 12'h077, 12'h078, 12'h079, 12'h07A,
		12'h07B, 12'h07C};
	logic [7:0] rv [9] = '{8'h00, 8'h00, 8'h04, 8'h00, 8'h08, 8'h24, 8'h00, 8'h00, 8'h00};
	always #50 clk_sys = ~clk_sys;
	ilcgd_top #(.PERIOD_CYCLES(PER)) ilcgd_top_i (.clk_sys(clk_sys), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .tx_in(tx_in), .tx_out(tx_out), .rx_in(rx_in),
		.loop_up_present(up), .loop_down_present(dn), .irq_n(irq_n));
	ilcgd_line_model ilcgd_line_model_i (.clk_sys(clk_sys), .rst_n(rst_n), .code(8'h08),
		.code_len(4'h5), .corrupt(corrupt), .rx_out(rx_in));
	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s exp %h got %h", s, e, g);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clk_sys);
		reg_wr <= 1'h0;
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk_sys);
		reg_rd <= 1'h0;
		@(negedge clk_sys);
		chk("reg", e, reg_rdata);
	endtask : rd
	task automatic txb(input logic f, input logic d, input logic e);
		@(posedge clk_sys);
		tx_in <= '{en: 1'h1, fbit: f, data: d};
		@(posedge clk_sys);
		tx_in <= '0;
		@(negedge clk_sys);
		chk("tx_out", {7'h00, e}, {7'h00, tx_out.data});
	endtask : txb
	task automatic wup(input logic l);
		for (int n = 0; n < 3 * PER && up !== l; n++) @(negedge clk_sys);
		chk("present", {7'h00, l}, {7'h00, up});
	endtask : wup
	task automatic wrap_up;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : wrap_up
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			bad_count++;
			wrap_up();
		end
	end
	initial begin
		int n;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'h1;
		for (int i = 0; i < 9; i++) rd(ofs[i], rv[i]);
		wr(12'h074, 8'hFF);
		rd(12'h074, 8'h0F);
		wr(12'h077, 8'hFF);
		rd(12'h077, 8'h00);
		wr(12'h075, PAT);
		for (int l = 0; l < 4; l++) begin
			n = 5 + l;
			wr(12'h074, 8'h00);
			wr(12'h074, 8'h08 | 8'(l));
			for (int i = 0; i < 2 * n; i++) txb(1'h0, ~PAT[7 - i % n], PAT[7 - i % n]);
		end
		wr(12'h074, 8'h00);
		wr(12'h074, 8'h08);
		txb(1'h1, 1'h0, 1'h0);
		txb(1'h0, 1'h0, 1'h1);
		wr(12'h074, 8'h00);
		wr(12'h074, 8'h0C);
		txb(1'h1, 1'h0, 1'h1);
		txb(1'h0, 1'h1, 1'h0);
		wr(12'h074, 8'h00);
		txb(1'h0, 1'h1, 1'h1);
		while (cyc < 126 * PER) @(negedge clk_sys);
		chk("present", 8'h00, {7'h00, up});
		// the hunting down detector also locks onto the reset down target
		wup(1'h1);
		chk("down_present", 8'h01, {7'h00, dn});
		rd(12'h077, 8'h03);
		chk("irq_n", 8'h01, {7'h00, irq_n});
		wr(12'h07A, 8'h02);
		repeat (2) @(negedge clk_sys);
		chk("irq_n", 8'h00, {7'h00, irq_n});
		wr(12'h07B, 8'h02);
		repeat (2) @(negedge clk_sys);
		chk("irq_n", 8'h01, {7'h00, irq_n});
		@(posedge clk_sys);
		corrupt <= 1'h1;
		wup(1'h0);
		chk("down_present", 8'h00, {7'h00, dn});
		chk("irq_n", 8'h00, {7'h00, irq_n});
		rd(12'h07B, 8'h03);
		rd(12'h07B, 8'h00);
		chk("irq_n", 8'h01, {7'h00, irq_n});
		wrap_up();
	end
endmodule : ilcgd_top_tb
